/* bench/nsf_host_model.sv */
// Host and configuration-store model facing the security block
module nsf_host_model
  import nsf_pkg::*;
(
  // Clock
  input  wire logic                 sys_clk_i,
  // Command port
  output nsf_pkg::nsf_req_type      req_o,
  input  wire nsf_pkg::nsf_rsp_type rsp_i,
  input  wire logic                 store_busy_i,
  // Store image
  input  wire nsf_pkg::nsf_nvm_type nvm_wr_i,
  input  wire logic                 nvm_store_i,
  output nsf_pkg::nsf_nvm_type      nvm_rd_o
);
  timeunit 1ns;
  timeprecision 1ns;

  nsf_req_type req_q   = '0;
  nsf_nvm_type store_q = '0;
  int          lost    = 0;

  assign req_o    = req_q;
  assign nvm_rd_o = store_q;

  // Contents outlive resets, as a real store would
  always @(posedge sys_clk_i) begin
    if (nvm_store_i === 1'b1) begin
      store_q <= nvm_wr_i;
    end
  end

  task automatic preset(input nsf_nvm_type img);
    store_q = img;
  endtask : preset

  task automatic xfer(input logic wr, input logic wd, input logic [7:0] cd,
                      input logic [15:0] dt, output logic ak, output logic [15:0] rd);
    int n;
    n = 0;
    // Silence while a store runs
    while (store_busy_i !== 1'b0 && n < 64) begin
      @(posedge sys_clk_i);
      n++;
    end
    @(posedge sys_clk_i);
    req_q <= '{valid: 1'b1, write: wr, word: wd, code: cd, data: dt};
    @(posedge sys_clk_i);
    req_q.valid <= 1'b0;
    #1;
    while (rsp_i.valid !== 1'b1 && n < 68) begin
      @(posedge sys_clk_i);
      #1;
      n++;
    end
    if (n >= 64) begin
      lost++;
    end
    ak = rsp_i.ack;
    rd = rsp_i.data;
  endtask : xfer
endmodule : nsf_host_model

/* bench/tb.sv */
// Self-checking testbench for the store security and first-fault block
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  import nsf_pkg::*;

  localparam int unsigned SC = 16;
  localparam logic [15:0] PW = 16'h5A3C;

  logic          sys_clk_i = 1'b0;
  logic          reset_i   = 1'b1;
  nsf_req_type   req_i;
  nsf_rsp_type   rsp_o;
  nsf_fault_type chan_a_fault_code_i = NSF_FLT_NONE;
  nsf_fault_type chan_b_fault_code_i = NSF_FLT_NONE;
  nsf_nvm_type   nvm_rd_i;
  nsf_nvm_type   nvm_wr_o;
  logic          nvm_store_o;
  logic          store_busy_o;
  logic          cfg_wr_block_o;
  logic          cml_flag_o;
  logic          host_alert_line_o;
  nsf_sec_type   sec_status_o;
  logic [7:0]    first_fault_register_o;
  logic          ak;
  logic [15:0]   rd;
  logic [7:0]    er;
  logic [2:0]    ca;
  logic [2:0]    cb;
  int            n_errors    = 0;
  int            checks_done = 0;
  int            n;

  nsf_nvm_security_fault_log #(.STORE_CYCLES(SC)) nsf_nvm_security_fault_log_i (
    .sys_clk_i, .reset_i, .req_i, .rsp_o, .chan_a_fault_code_i, .chan_b_fault_code_i,
    .nvm_rd_i, .nvm_wr_o, .nvm_store_o, .store_busy_o, .cfg_wr_block_o, .cml_flag_o,
    .host_alert_line_o, .sec_status_o, .first_fault_register_o);

  nsf_host_model nsf_host_model_i (
    .sys_clk_i, .req_o(req_i), .rsp_i(rsp_o), .store_busy_i(store_busy_o),
    .nvm_wr_i(nvm_wr_o), .nvm_store_i(nvm_store_o), .nvm_rd_o(nvm_rd_i));

  initial begin
    forever #25 sys_clk_i = ~sys_clk_i;
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic chk_bit(input logic got, input logic exp);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_bit

  function automatic logic [15:0] ck(input logic [15:0] k, input logic [7:0] r);
    return k + {8'h00, r} + {r, 8'h00};
  endfunction : ck

  task automatic cmd(input logic wr, input logic wd, input logic [7:0] cd, input logic [15:0] dt);
    nsf_host_model_i.xfer(wr, wd, cd, dt, ak, rd);
  endtask : cmd

  task automatic power_cycle();
    @(posedge sys_clk_i);
    reset_i <= 1'b1;
    repeat (6) @(posedge sys_clk_i);
    #1;
    chk(16'(sec_status_o), 16'h0001);
    chk_bit(cfg_wr_block_o, 1'b1);
    @(posedge sys_clk_i);
    reset_i <= 1'b0;
    repeat (2) @(posedge sys_clk_i);
  endtask : power_cycle

  task automatic fault(input logic [2:0] a, input logic [2:0] b);
    @(posedge sys_clk_i);
    chan_a_fault_code_i <= nsf_fault_type'(a);
    chan_b_fault_code_i <= nsf_fault_type'(b);
    @(posedge sys_clk_i);
    chan_a_fault_code_i <= NSF_FLT_NONE;
    chan_b_fault_code_i <= NSF_FLT_NONE;
    #1;
  endtask : fault

  task automatic complete_run();
    $display("checks_done %0d n_errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : complete_run

  initial begin
    void'($urandom(77));
    nsf_host_model_i.preset('{key: PW, rec: 8'h00});
    power_cycle();
    cmd(1'b0, 1'b1, 8'hFA, 16'h0000);
    chk(rd, 16'h0001);
    cmd(1'b1, 1'b0, 8'hD8, 16'h0000);
    chk_bit(ak, 1'b0);
    cmd(1'b1, 1'b0, 8'h00, 16'h0001);
    chk_bit(ak, 1'b1);
    cmd(1'b1, 1'b0, 8'h04, 16'h0002);
    chk_bit(ak, 1'b1);
    // Only the top bit differs from the key
    cmd(1'b1, 1'b1, 8'hFA, PW ^ 16'h8000);
    chk_bit(ak, 1'b0);
    cmd(1'b1, 1'b1, 8'hFA, PW);
    chk_bit(ak, 1'b0);
    cmd(1'b0, 1'b1, 8'hFA, 16'h0000);
    chk(rd, 16'h0002);
    power_cycle();
    cmd(1'b1, 1'b1, 8'hFA, PW);
    chk_bit(ak, 1'b1);
    cmd(1'b0, 1'b1, 8'hFA, 16'h0000);
    chk(rd, 16'h0000);
    chk_bit(cfg_wr_block_o, 1'b0);
    cmd(1'b0, 1'b0, 8'hFA, 16'h0000);
    chk_bit(ak, 1'b0);
    // Identity read; the reference device answered zero
    cmd(1'b0, 1'b0, 8'h55, 16'h0000);
    chk(rd, 16'h0000);
    for (int i = 1; i < 8; i++) begin
      cmd(1'b1, 1'b0, 8'hD8, 16'h0000);
      chk_bit(ak, 1'b1);
      chk(16'(first_fault_register_o), 16'h0000);
      ca = 3'(i);
      cb = 3'($urandom_range(7, 1));
      er = {2'b00, cb, ca};
      fault(ca, cb);
      chk(16'(first_fault_register_o), 16'(er));
      fault(3'($urandom), 3'($urandom));
      chk(16'(first_fault_register_o), 16'(er));
    end
    cmd(1'b0, 1'b0, 8'hD8, 16'h0000);
    chk(rd, 16'(er));
    cmd(1'b0, 1'b1, 8'hD8, 16'h0000);
    chk_bit(ak, 1'b0);
    cmd(1'b1, 1'b0, 8'hD8, 16'h0009);
    chk_bit(ak, 1'b0);
    @(posedge sys_clk_i);
    #1;
    chk(16'(first_fault_register_o), 16'(er));
    chk_bit(cml_flag_o, 1'b1);
    chk_bit(host_alert_line_o, 1'b1);
    cmd(1'b1, 1'b0, 8'h03, 16'h0000);
    chk_bit(ak, 1'b1);
    chk_bit(cml_flag_o, 1'b0);
    chk_bit(host_alert_line_o, 1'b0);
    cmd(1'b1, 1'b1, 8'h9E, 16'h0000);
    chk_bit(ak, 1'b0);
    cmd(1'b1, 1'b0, 8'h00, 16'h0000);
    chk_bit(ak, 1'b1);
    cmd(1'b1, 1'b0, 8'h00, 16'h0001);
    chk_bit(ak, 1'b1);
    cmd(1'b1, 1'b1, 8'hFA, 16'hFFFF);
    chk_bit(ak, 1'b1);
    // Conversion is never enabled here, so the store may be programmed
    cmd(1'b1, 1'b0, 8'h11, 16'h0000);
    chk_bit(nvm_store_o, 1'b1);
    chk(nvm_wr_o.key, 16'hFFFF);
    chk(16'(nvm_wr_o.rec), 16'(er));
    n = 0;
    while (store_busy_o === 1'b1 && n < 40) begin
      @(posedge sys_clk_i);
      #1;
      n++;
    end
    chk(16'(n), 16'(SC));
    cmd(1'b0, 1'b1, 8'h9E, 16'h0000);
    chk(rd, ck(16'hFFFF, er));
    power_cycle();
    cmd(1'b0, 1'b1, 8'hFA, 16'h0000);
    chk(rd, 16'h0000);
    chk(16'(first_fault_register_o), 16'(er));
    cmd(1'b1, 1'b0, 8'hD8, 16'h0000);
    chk_bit(ak, 1'b1);
    cmd(1'b1, 1'b0, 8'h11, 16'h0000);
    chk_bit(ak, 1'b1);
    repeat (SC) @(posedge sys_clk_i);
    power_cycle();
    cmd(1'b0, 1'b0, 8'hD8, 16'h0000);
    chk(rd, 16'h0000);
    fault(3'h3, 3'h0);
    chk(16'(first_fault_register_o), 16'h0003);
    chk(16'(nsf_host_model_i.lost), 16'h0000);
    complete_run();
  end
endmodule : tb

/* rtl/nsf_nvm_security_fault_log.sv */
// Configuration-store password lock, store sequencing and first-fault recorder
module nsf_nvm_security_fault_log
  import nsf_pkg::*;
#(
  parameter int unsigned STORE_CYCLES = NSF_STORE_CYCLES
) (
  // Clock and reset
  input  wire logic                   sys_clk_i,
  input  wire logic                   reset_i,
  // Command port
  input  wire nsf_pkg::nsf_req_type   req_i,
  output nsf_pkg::nsf_rsp_type        rsp_o,
  // Catastrophic fault events per channel
  input  wire nsf_pkg::nsf_fault_type chan_a_fault_code_i,
  input  wire nsf_pkg::nsf_fault_type chan_b_fault_code_i,
  // Non-volatile store image
  input  wire nsf_pkg::nsf_nvm_type   nvm_rd_i,
  output nsf_pkg::nsf_nvm_type        nvm_wr_o,
  output logic                        nvm_store_o,
  // Status
  output logic                        store_busy_o,
  output logic                        cfg_wr_block_o,
  output logic                        cml_flag_o,
  output logic                        host_alert_line_o,
  output nsf_pkg::nsf_sec_type        sec_status_o,
  output logic [7:0]                  first_fault_register_o
);
  import nsf_pkg::*;

  typedef struct packed {
    logic          loaded;
    nsf_sec_type   sec;
    logic [15:0]   key_nvm;
    logic [15:0]   key_stage;
    logic [7:0]    rec;
    logic [15:0]   chk;
    logic [31:0]   cnt;
    logic          busy;
    logic          cml;
    logic          alert;
    nsf_rsp_type   rsp;
    nsf_nvm_type   nvm_wr;
    logic          store;
    logic          block;
  } nsf_state_type;

  nsf_state_type s_q;
  nsf_state_type s_d;
  logic          wr_allowed;

  always_comb begin
    s_d         = s_q;
    s_d.rsp     = '0;
    s_d.store   = 1'b0;
    // Gate every write except paging, phase and the password itself
    wr_allowed  = (s_q.sec == NSF_SEC_OFF) || (req_i.code == NSF_CMD_PAGE) ||
                  (req_i.code == NSF_CMD_PHASE) || (req_i.code == NSF_CMD_KEY);
    if (!s_q.loaded) begin
      // Captured once after release; the store image must be steady by then
      s_d.loaded    = 1'b1;
      s_d.key_nvm   = nvm_rd_i.key;
      s_d.key_stage = nvm_rd_i.key;
      s_d.rec       = nvm_rd_i.rec & NSF_REC_FIELD_MASK;
      s_d.chk       = nsf_checksum(nvm_rd_i.key, nvm_rd_i.rec & NSF_REC_FIELD_MASK);
      s_d.sec       = (nvm_rd_i.key == NSF_KEY_OPEN) ? NSF_SEC_OFF : NSF_SEC_ON;
    end else begin
      if (s_q.cnt != 32'h0) begin
        s_d.cnt = s_q.cnt - 32'h1;
      end
      s_d.busy = (s_d.cnt != 32'h0);
      if (req_i.valid) begin
        s_d.rsp.valid = 1'b1;
        if (s_q.busy || (req_i.write && !wr_allowed)) begin
          s_d.rsp.ack = 1'b0;
        end else begin
          case (req_i.code)
            NSF_CMD_KEY: begin
              if (!req_i.word) begin
                s_d.rsp.ack = 1'b0;
              end else if (!req_i.write) begin
                s_d.rsp.ack  = 1'b1;
                s_d.rsp.data = {14'h0000, s_q.sec};
              end else begin
                case (s_q.sec)
                  NSF_SEC_OFF: begin
                    s_d.key_stage = req_i.data;
                    s_d.rsp.ack   = 1'b1;
                  end
                  NSF_SEC_ON: begin
                    if (req_i.data == s_q.key_nvm) begin
                      s_d.sec     = NSF_SEC_OFF;
                      s_d.rsp.ack = 1'b1;
                    end else begin
                      s_d.sec     = NSF_SEC_LOCK;
                      s_d.rsp.ack = 1'b0;
                    end
                  end
                  default: begin
                    // Locked: no password can release it, only reset
                    s_d.rsp.ack = 1'b0;
                  end
                endcase
              end
            end
            NSF_CMD_FAULT_REC: begin
              if (req_i.word) begin
                s_d.rsp.ack = 1'b0;
              end else if (!req_i.write) begin
                s_d.rsp.ack  = 1'b1;
                s_d.rsp.data = {8'h00, s_q.rec};
              end else if (req_i.data[7:0] == NSF_REC_CLEAR) begin
                s_d.rec     = NSF_REC_CLEAR;
                s_d.rsp.ack = 1'b1;
              end else begin
                s_d.cml     = 1'b1;
                s_d.alert   = 1'b1;
                s_d.rsp.ack = 1'b0;
              end
            end
            NSF_CMD_STORE_ALL: begin
              if (req_i.write) begin
                // Commits staged key and current record; rest of device waits on busy
                s_d.store      = 1'b1;
                s_d.nvm_wr.key = s_q.key_stage;
                s_d.nvm_wr.rec = s_q.rec;
                s_d.chk        = nsf_checksum(s_q.key_stage, s_q.rec);
                s_d.cnt        = STORE_CYCLES;
                s_d.busy       = 1'b1;
                s_d.rsp.ack    = 1'b1;
              end else begin
                s_d.rsp.ack = 1'b0;
              end
            end
            NSF_CMD_SERIAL: begin
              s_d.rsp.ack  = !req_i.write;
              s_d.rsp.data = req_i.write ? 16'h0000 : s_q.chk;
            end
            NSF_CMD_CLEAR_FAULTS: begin
              s_d.rsp.ack = req_i.write;
              if (req_i.write) begin
                s_d.cml   = 1'b0;
                s_d.alert = 1'b0;
              end
            end
            default: begin
              // Other commands belong to neighbouring logic
              s_d.rsp.ack = 1'b1;
            end
          endcase
        end
      end
    end
    // Capture after any clear so a fault in the clearing cycle wins
    if (s_q.loaded && chan_a_fault_code_i != NSF_FLT_NONE &&
        s_d.rec[NSF_REC_A_LSB +: 3] == 3'b000) begin
      s_d.rec[NSF_REC_A_LSB +: 3] = chan_a_fault_code_i;
    end
    if (s_q.loaded && chan_b_fault_code_i != NSF_FLT_NONE &&
        s_d.rec[NSF_REC_B_LSB +: 3] == 3'b000) begin
      s_d.rec[NSF_REC_B_LSB +: 3] = chan_b_fault_code_i;
    end
    // Kept as its own flop so the rest of the device sees a clean level
    s_d.block = (s_d.sec != NSF_SEC_OFF);
  end

  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      s_q       <= '0;
      s_q.sec   <= NSF_SEC_ON;
      s_q.block <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign rsp_o                  = s_q.rsp;
  assign nvm_wr_o               = s_q.nvm_wr;
  assign nvm_store_o            = s_q.store;
  assign store_busy_o           = s_q.busy;
  assign cfg_wr_block_o         = s_q.block;
  assign cml_flag_o             = s_q.cml;
  assign host_alert_line_o      = s_q.alert;
  assign sec_status_o           = s_q.sec;
  assign first_fault_register_o = s_q.rec;

  // Checks
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (reset_i);

  logic key_wr_go;
  logic rec_wr_go;
  assign key_wr_go = req_i.valid && req_i.write && req_i.word && !s_q.busy && s_q.loaded &&
                     (req_i.code == NSF_CMD_KEY);
  assign rec_wr_go = req_i.valid && req_i.write && !req_i.word && !s_q.busy && s_q.loaded &&
                     (req_i.code == NSF_CMD_FAULT_REC) && wr_allowed;

  property p_lock_sticky;
    (s_q.sec == NSF_SEC_LOCK) |=> (s_q.sec == NSF_SEC_LOCK);
  endproperty
  a_lock_sticky: assert property (p_lock_sticky) else $error("lockout released");

  property p_wrong_pw;
    (key_wr_go && s_q.sec == NSF_SEC_ON && req_i.data != s_q.key_nvm)
      |=> (s_q.sec == NSF_SEC_LOCK) && s_q.rsp.valid && !s_q.rsp.ack;
  endproperty
  a_wrong_pw: assert property (p_wrong_pw) else $error("wrong password not locked");

  property p_right_pw;
    (key_wr_go && s_q.sec == NSF_SEC_ON && req_i.data == s_q.key_nvm)
      |=> (s_q.sec == NSF_SEC_OFF) && s_q.rsp.ack && !cfg_wr_block_o;
  endproperty
  a_right_pw: assert property (p_right_pw) else $error("correct password refused");

  property p_lock_rejects;
    (key_wr_go && s_q.sec == NSF_SEC_LOCK) |=> !s_q.rsp.ack ##1 (s_q.sec == NSF_SEC_LOCK);
  endproperty
  a_lock_rejects: assert property (p_lock_rejects) else $error("locked took password");

  property p_key_read;
    (req_i.valid && !req_i.write && req_i.word && req_i.code == NSF_CMD_KEY && !s_q.busy &&
     s_q.loaded) |=> s_q.rsp.ack && (s_q.rsp.data == {14'h0000, $past(s_q.sec)});
  endproperty
  a_key_read: assert property (p_key_read) else $error("key read not status code");

  property p_key_byte;
    (req_i.valid && !req_i.word && req_i.code == NSF_CMD_KEY && s_q.loaded)
      |=> s_q.rsp.valid && !s_q.rsp.ack;
  endproperty
  a_key_byte: assert property (p_key_byte) else $error("byte access to key taken");

  property p_block;
    (req_i.valid && req_i.write && s_q.loaded && s_q.sec != NSF_SEC_OFF &&
     req_i.code != NSF_CMD_PAGE && req_i.code != NSF_CMD_PHASE && req_i.code != NSF_CMD_KEY)
      |=> !s_q.rsp.ack && !s_q.store;
  endproperty
  a_block: assert property (p_block) else $error("write taken while secured");

  property p_first_only;
    (s_q.loaded && s_q.rec[2:0] != 3'b000 && !(rec_wr_go && req_i.data[7:0] == 8'h00))
      |=> (s_q.rec[2:0] == $past(s_q.rec[2:0]));
  endproperty
  a_first_only: assert property (p_first_only) else $error("later fault overwrote");

  property p_capture_b;
    (s_q.loaded && s_q.rec[5:3] == 3'b000 && chan_b_fault_code_i != NSF_FLT_NONE)
      |=> (s_q.rec[5:3] == $past(chan_b_fault_code_i));
  endproperty
  a_capture_b: assert property (p_capture_b) else $error("fault B not captured");

  property p_bad_rec_write;
    (rec_wr_go && req_i.data[7:0] != 8'h00 && chan_a_fault_code_i == NSF_FLT_NONE &&
     chan_b_fault_code_i == NSF_FLT_NONE)
      |=> cml_flag_o && host_alert_line_o && !s_q.rsp.ack && $stable(s_q.rec);
  endproperty
  a_bad_rec_write: assert property (p_bad_rec_write) else $error("bad record write kept");

  property p_top_zero;
    s_q.rec[7:6] == 2'b00;
  endproperty
  a_top_zero: assert property (p_top_zero) else $error("record bits 7:6 set");

  property p_store;
    (req_i.valid && req_i.write && req_i.code == NSF_CMD_STORE_ALL && !s_q.busy && s_q.loaded &&
     wr_allowed) |=> nvm_store_o && (nvm_wr_o.rec == $past(s_q.rec)) ##1 store_busy_o[*4];
  endproperty
  a_store: assert property (p_store) else $error("store not committed");

  property p_serial;
    (req_i.valid && !req_i.write && req_i.code == NSF_CMD_SERIAL && !s_q.busy && s_q.loaded)
      |=> s_q.rsp.ack && (s_q.rsp.data == s_q.chk);
  endproperty
  a_serial: assert property (p_serial) else $error("serial not checksum");

  property p_power_on;
    $rose(s_q.loaded) |->
      (s_q.sec == (($past(nvm_rd_i.key) == NSF_KEY_OPEN) ? NSF_SEC_OFF : NSF_SEC_ON));
  endproperty
  a_power_on: assert property (p_power_on) else $error("power-on security wrong");

  property p_rec_word;
    (req_i.valid && req_i.word && req_i.code == NSF_CMD_FAULT_REC && s_q.loaded)
      |=> s_q.rsp.valid && !s_q.rsp.ack;
  endproperty
  a_rec_word: assert property (p_rec_word) else $error("word access to record taken");

  property p_clear_rec;
    (rec_wr_go && req_i.data[7:0] == 8'h00 && chan_a_fault_code_i == NSF_FLT_NONE &&
     chan_b_fault_code_i == NSF_FLT_NONE) |=> (s_q.rec == 8'h00) && s_q.rsp.ack;
  endproperty
  a_clear_rec: assert property (p_clear_rec) else $error("record clear not taken");

  property p_capture_a;
    (s_q.loaded && s_q.rec[2:0] == 3'b000 && chan_a_fault_code_i != NSF_FLT_NONE)
      |=> (s_q.rec[2:0] == $past(chan_a_fault_code_i));
  endproperty
  a_capture_a: assert property (p_capture_a) else $error("fault A not captured");

  property p_clear_flags;
    (req_i.valid && req_i.write && req_i.code == NSF_CMD_CLEAR_FAULTS && !s_q.busy &&
     s_q.loaded && wr_allowed) |=> s_q.rsp.ack && !cml_flag_o && !host_alert_line_o;
  endproperty
  a_clear_flags: assert property (p_clear_flags) else $error("flags not cleared");

  property p_serial_write;
    (req_i.valid && req_i.write && req_i.code == NSF_CMD_SERIAL && s_q.loaded)
      |=> s_q.rsp.valid && !s_q.rsp.ack;
  endproperty
  a_serial_write: assert property (p_serial_write) else $error("serial write taken");

  property p_store_pulse;
    nvm_store_o |=> !nvm_store_o;
  endproperty
  a_store_pulse: assert property (p_store_pulse) else $error("store pulse too long");

  c_lock:   cover property (key_wr_go && s_q.sec == NSF_SEC_ON ##1 s_q.sec == NSF_SEC_LOCK);
  c_unlock: cover property (key_wr_go && s_q.sec == NSF_SEC_ON ##1 s_q.sec == NSF_SEC_OFF);
  c_fault:  cover property (s_q.rec[2:0] == 3'b000 ##1 s_q.rec[2:0] != 3'b000);
  c_store:  cover property (nvm_store_o);
  c_reject: cover property (rec_wr_go && req_i.data[7:0] != 8'h00);

endmodule : nsf_nvm_security_fault_log

/* rtl/nsf_pkg.sv */
// Package for the configuration-store security and first-fault recorder block
package nsf_pkg;

  // Command codes seen by this block
  localparam logic [7:0]  NSF_CMD_PAGE         = 8'h00;
  localparam logic [7:0]  NSF_CMD_CLEAR_FAULTS = 8'h03;
  localparam logic [7:0]  NSF_CMD_PHASE        = 8'h04;
  localparam logic [7:0]  NSF_CMD_STORE_ALL    = 8'h11;
  localparam logic [7:0]  NSF_CMD_SERIAL       = 8'h9E;
  localparam logic [7:0]  NSF_CMD_FAULT_REC    = 8'hD8;
  localparam logic [7:0]  NSF_CMD_KEY          = 8'hFA;

  // Key and record layout
  localparam logic [15:0] NSF_KEY_OPEN         = 16'hFFFF;
  localparam int unsigned NSF_REC_A_LSB        = 0;
  localparam int unsigned NSF_REC_B_LSB        = 3;
  localparam logic [7:0]  NSF_REC_FIELD_MASK   = 8'h3F;
  localparam logic [7:0]  NSF_REC_CLEAR        = 8'h00;

  // Store timing
  localparam int unsigned NSF_STORE_TIME_MS    = 100;
  localparam int unsigned NSF_CLK_HZ           = 20_000_000;
  localparam int unsigned NSF_STORE_CYCLES     = NSF_STORE_TIME_MS * (NSF_CLK_HZ / 1000);

  // Security state; the code doubles as the value read from the key register
  typedef enum logic [1:0] {
    NSF_SEC_OFF  = 2'b00,
    NSF_SEC_ON   = 2'b01,
    NSF_SEC_LOCK = 2'b10
  } nsf_sec_type;

  // Per-channel catastrophic fault codes
  typedef enum logic [2:0] {
    NSF_FLT_NONE     = 3'b000,
    NSF_FLT_OV_OFF   = 3'b001,
    NSF_FLT_OV_ON    = 3'b010,
    NSF_FLT_IIN_OC   = 3'b011,
    NSF_FLT_IOUT_OC  = 3'b100,
    NSF_FLT_OT       = 3'b101,
    NSF_FLT_PSTAGE   = 3'b110,
    NSF_FLT_IN_OP    = 3'b111
  } nsf_fault_type;

  // Command request from the bus front end
  typedef struct packed {
    logic        valid;
    logic        write;
    logic        word;
    logic [7:0]  code;
    logic [15:0] data;
  } nsf_req_type;

  // Answer to a request, one cycle later
  typedef struct packed {
    logic        valid;
    logic        ack;
    logic [15:0] data;
  } nsf_rsp_type;

  // Image of the non-volatile contents kept by this block
  typedef struct packed {
    logic [15:0] key;
    logic [7:0]  rec;
  } nsf_nvm_type;

  function automatic logic [15:0] nsf_checksum(input logic [15:0] key, input logic [7:0] rec);
    nsf_checksum = key + {8'h00, rec} + {rec, 8'h00};
  endfunction : nsf_checksum

endpackage : nsf_pkg
